// *** design/spi_port_pkg.sv ***
// constants, register map and field layout of the serial peripheral port
package spi_port_pkg;
	localparam int unsigned ADDR_W = 12;
	localparam int unsigned DATA_W = 32;
	// printed register indexes; byte address is four times the index
	localparam logic [7:0] IDX_FLAGS  = 8'h0C;
	localparam logic [7:0] IDX_BUF    = 8'h13;
	localparam logic [7:0] IDX_CTRL   = 8'h14;
	localparam logic [7:0] IDX_PINCTL = 8'h15;
	localparam logic [7:0] IDX_ENAB   = 8'h8C;
	localparam logic [7:0] IDX_STAT   = 8'h94;
	localparam logic [ADDR_W-1:0] ADR_FLAGS  = {2'h0, IDX_FLAGS, 2'h0};
	localparam logic [ADDR_W-1:0] ADR_BUF    = {2'h0, IDX_BUF, 2'h0};
	localparam logic [ADDR_W-1:0] ADR_CTRL   = {2'h0, IDX_CTRL, 2'h0};
	localparam logic [ADDR_W-1:0] ADR_PINCTL = {2'h0, IDX_PINCTL, 2'h0};
	localparam logic [ADDR_W-1:0] ADR_ENAB   = {2'h0, IDX_ENAB, 2'h0};
	localparam logic [ADDR_W-1:0] ADR_STAT   = {2'h0, IDX_STAT, 2'h0};
	// field positions
	localparam int unsigned PIF_BIT     = 3;
	localparam int unsigned PIE_BIT     = 3;
	localparam int unsigned WRITE_COLLISION_FLAG_BIT    = 7;
	localparam int unsigned OV_BIT      = 6;
	localparam int unsigned EN_BIT      = 5;
	localparam int unsigned CKP_BIT     = 4;
	localparam int unsigned MODE_MSB    = 3;
	localparam int unsigned CFG_MSB     = 5;
	localparam int unsigned SMP_BIT     = 7;
	localparam int unsigned CKE_BIT     = 6;
	localparam int unsigned BF_BIT      = 0;
	localparam int unsigned SDO_DIS_BIT = 0;
	// reset values
	localparam logic [5:0] CFG_RST = 6'h00;
	localparam logic [7:0] BYTE_ZERO = 8'h00;
	// mode field codes
	localparam logic [3:0] MODE_DIV4     = 4'h0;
	localparam logic [3:0] MODE_DIV16    = 4'h1;
	localparam logic [3:0] MODE_DIV64    = 4'h2;
	localparam logic [3:0] MODE_TMR2     = 4'h3;
	localparam logic [3:0] MODE_SLAVE_SS = 4'h4;
	localparam logic [3:0] MODE_SLAVE    = 4'h5;
	// half bit periods in clk cycles, minus one
	localparam logic [5:0] HALF_DIV4_M1  = 6'h01;
	localparam logic [5:0] HALF_DIV16_M1 = 6'h07;
	localparam logic [5:0] HALF_DIV64_M1 = 6'h1F;
	// half-tick indexes of a master byte
	localparam logic [4:0] TICK_FIRST     = 5'h00;
	localparam logic [4:0] TICK_LAST      = 5'h0F;
	localparam logic [4:0] TICK_LAST_LATE = 5'h10;
	localparam logic [3:0] BIT_LAST       = 4'h7;
	// bus responses
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	typedef enum logic [1:0] {
		ST_IDLE  = 2'b01,
		ST_SHIFT = 2'b10
	} xfer_state_type;
endpackage

// *** design/sync_serial_spi_port.sv ***
// byte-wide spi master/slave port with an axi4-lite register slave
`timescale 1ns/1ps
// Operation
// - each byte transfer shifts eight bits out and eight in together
// - all four clock polarity and output edge combinations work
// - master drives serial clock at set rate; slave takes it as input
// - mode, polarity, phase, edge and rate come from control and status
// - port runs only while enabled; clearing enable resets the engine
// - master buffer write starts shifting at once
// - with data out disabled, bytes still arrive and set flags
// - serial clock idles at the clock polarity bit
// - bytes move most significant bit first
// - master rate is clock over four, sixteen, sixty-four or timer tick over two
// - with edge bit set, first output bit is valid before first edge
// - in master mode, sample bit picks middle or end of output bit time
// - slave shifts on external clock; last bit sets interrupt flag
// - slave works in sleep and a received byte wakes the device
// - in select-pin slave mode, select high resets the shifter
// - transfer buffer keeps its contents through reset
module sync_serial_spi_port (
	// clock and reset
	input  wire logic        clk,
	input  wire logic        rst,
	// axi4-lite write
	input  wire logic [11:0] awaddr,
	input  wire logic        awvalid,
	output logic             awready,
	input  wire logic [31:0] wdata,
	input  wire logic [3:0]  wstrb,
	input  wire logic        wvalid,
	output logic             wready,
	output logic [1:0]       bresp,
	output logic             bvalid,
	input  wire logic        bready,
	// axi4-lite read
	input  wire logic [11:0] araddr,
	input  wire logic        arvalid,
	output logic             arready,
	output logic [31:0]      rdata,
	output logic [1:0]       rresp,
	output logic             rvalid,
	input  wire logic        rready,
	// serial pins
	input  wire logic        sck_in,
	output logic             sck_out,
	output logic             sck_oe_n,
	input  wire logic        serial_data_in_pin,
	output logic             sdo_out,
	output logic             sdo_oe_n,
	input  wire logic        ss_n,
	// system
	input  wire logic        timer2_tick,
	input  wire logic        sleep_mode,
	output logic             wake_request,
	output logic             irq
);
	spi_port_pkg::xfer_state_type state;
	logic [5:0]  cfg;
	logic        write_collision_flag;
	logic        rx_ov;
	logic        input_sample_phase_bit;
	logic        cke;
	logic        buf_full;
	logic        pif;
	logic        pie;
	logic        sdo_dis;
	logic [7:0]  xfer_buf;
	logic [7:0]  tx_sr;
	logic [7:0]  rx_sr;
	logic [4:0]  tick_idx;
	logic [5:0]  div_cnt;
	logic [3:0]  bit_cnt;
	logic [1:0]  m_sample_d;
	logic [1:0]  m_done_d;
	logic        sck_s1;
	logic        sck_s2;
	logic        sck_s3;
	logic        sdi_s1;
	logic        sdi_s2;
	logic        ss_s1;
	logic        ss_s2;
	logic        aw_hold;
	logic        w_hold;
	logic [11:0] aw_addr_h;
	logic [7:0]  w_byte_h;
	logic        w_strb_h;
	logic        next_bvalid;
	logic        next_aw_hold;
	logic        next_w_hold;
	logic        next_rvalid;
	logic        next_sck;
	logic [7:0]  rd_word;

	// configuration decode
	wire       en        = cfg[spi_port_pkg::EN_BIT];
	wire       clock_polarity_bit       = cfg[spi_port_pkg::CKP_BIT];
	wire [3:0] mode      = cfg[spi_port_pkg::MODE_MSB:0];
	wire       is_master = en && (mode <= spi_port_pkg::MODE_TMR2);
	wire       is_slave  = en && (mode == spi_port_pkg::MODE_SLAVE_SS ||
	                              mode == spi_port_pkg::MODE_SLAVE);
	wire       ss_mode   = mode == spi_port_pkg::MODE_SLAVE_SS;
	wire       ss_active = !ss_mode || !ss_s2;
	wire       slave_rst = is_slave && ss_mode && ss_s2;
	wire       slave_on  = is_slave && ss_active;
	wire       late      = input_sample_phase_bit && !cke;

	// bus decode
	wire wr_go   = aw_hold && w_hold && !bvalid;
	wire wen     = wr_go && w_strb_h;
	wire rd_go   = arvalid && arready;
	wire wr_map  = aw_addr_h == spi_port_pkg::ADR_FLAGS ||
	               aw_addr_h == spi_port_pkg::ADR_BUF ||
	               aw_addr_h == spi_port_pkg::ADR_CTRL ||
	               aw_addr_h == spi_port_pkg::ADR_PINCTL ||
	               aw_addr_h == spi_port_pkg::ADR_ENAB ||
	               aw_addr_h == spi_port_pkg::ADR_STAT;
	wire rd_map  = araddr == spi_port_pkg::ADR_FLAGS ||
	               araddr == spi_port_pkg::ADR_BUF ||
	               araddr == spi_port_pkg::ADR_CTRL ||
	               araddr == spi_port_pkg::ADR_PINCTL ||
	               araddr == spi_port_pkg::ADR_ENAB ||
	               araddr == spi_port_pkg::ADR_STAT;
	wire wr_flags  = wen && aw_addr_h == spi_port_pkg::ADR_FLAGS;
	wire wr_buf    = wen && aw_addr_h == spi_port_pkg::ADR_BUF;
	wire wr_ctrl   = wen && aw_addr_h == spi_port_pkg::ADR_CTRL;
	wire wr_pinctl = wen && aw_addr_h == spi_port_pkg::ADR_PINCTL;
	wire wr_enab   = wen && aw_addr_h == spi_port_pkg::ADR_ENAB;
	wire wr_stat   = wen && aw_addr_h == spi_port_pkg::ADR_STAT;
	wire buf_rd    = rd_go && araddr == spi_port_pkg::ADR_BUF;

	// transfer engine decode
	wire xfer_busy  = state == spi_port_pkg::ST_SHIFT || bit_cnt != 4'h0 ||
	                  m_done_d != 2'h0;
	wire buf_take   = wr_buf && !xfer_busy && en;
	wire collide    = wr_buf && xfer_busy;
	wire start      = buf_take && is_master;
	wire [5:0] half_m1 =
		(mode == spi_port_pkg::MODE_DIV16) ? spi_port_pkg::HALF_DIV16_M1 :
		(mode == spi_port_pkg::MODE_DIV64) ? spi_port_pkg::HALF_DIV64_M1 :
		spi_port_pkg::HALF_DIV4_M1;
	wire rate_tick  = (mode == spi_port_pkg::MODE_TMR2) ? timer2_tick :
	                  div_cnt == half_m1;
	wire half_tick  = is_master && state == spi_port_pkg::ST_SHIFT &&
	                  rate_tick;
	wire [4:0] tick_last = late ? spi_port_pkg::TICK_LAST_LATE :
	                       spi_port_pkg::TICK_LAST;
	wire m_out    = half_tick && (tick_idx[0] == cke) &&
	                tick_idx != spi_port_pkg::TICK_LAST_LATE;
	wire m_sample = half_tick && (tick_idx[0] == (!cke ^ input_sample_phase_bit)) &&
	                !(late && tick_idx == spi_port_pkg::TICK_FIRST);
	wire m_toggle = half_tick && tick_idx <= spi_port_pkg::TICK_LAST;
	wire m_done   = half_tick && tick_idx == tick_last;
	wire sck_edge = sck_s2 ^ sck_s3;
	wire s_lead   = slave_on && sck_edge && (sck_s2 != clock_polarity_bit);
	wire s_trail  = slave_on && sck_edge && (sck_s2 == clock_polarity_bit);
	wire s_out    = cke ? s_trail : s_lead;
	wire s_sample = cke ? s_lead : s_trail;
	wire shift_out = m_out || s_out;
	wire sample_now = m_sample_d[1] || s_sample;
	wire s_done   = s_sample && bit_cnt == spi_port_pkg::BIT_LAST;
	wire xfer_done = m_done_d[1] || s_done;
	wire [7:0] rx_next  = {rx_sr[6:0], sdi_s2};
	wire [7:0] captured = sample_now ? rx_next : rx_sr;
	wire load_ok  = !buf_full || buf_rd;
	wire ov_set   = xfer_done && !load_ok;

	// pin synchronisers; the second stage feeds logic, and the clock's third stage marks its edges
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			sck_s1 <= 1'b0;
			sck_s2 <= 1'b0;
			sck_s3 <= 1'b0;
			sdi_s1 <= 1'b0;
			sdi_s2 <= 1'b0;
			ss_s1  <= 1'b1;
			ss_s2  <= 1'b1;
		end else begin
			sck_s1 <= sck_in;
			sck_s2 <= sck_s1;
			sck_s3 <= sck_s2;
			sdi_s1 <= serial_data_in_pin;
			sdi_s2 <= sdi_s1;
			ss_s1  <= ss_n;
			ss_s2  <= ss_s1;
		end
	end

	// master sequencer: sixteen clock edges per byte
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state    <= spi_port_pkg::ST_IDLE;
			tick_idx <= spi_port_pkg::TICK_FIRST;
			div_cnt  <= 6'h00;
		end else if (!is_master) begin
			state    <= spi_port_pkg::ST_IDLE;
			tick_idx <= spi_port_pkg::TICK_FIRST;
			div_cnt  <= 6'h00;
		end else if (start) begin
			state    <= spi_port_pkg::ST_SHIFT;
			tick_idx <= spi_port_pkg::TICK_FIRST;
			div_cnt  <= 6'h00;
		end else if (state == spi_port_pkg::ST_SHIFT) begin
			div_cnt <= rate_tick ? 6'h00 : div_cnt + 6'h01;
			if (m_done)
				state <= spi_port_pkg::ST_IDLE;
			if (half_tick)
				tick_idx <= tick_idx + 5'h01;
		end
	end

	// data in lags our own clock edge by the synchroniser, so master
	// sampling and byte end are taken two cycles after the edge
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			m_sample_d <= 2'h0;
			m_done_d   <= 2'h0;
		end else if (!is_master) begin
			m_sample_d <= 2'h0;
			m_done_d   <= 2'h0;
		end else begin
			m_sample_d <= {m_sample_d[0], m_sample};
			m_done_d   <= {m_done_d[0], m_done};
		end
	end

	// serial clock drive; idles at the polarity bit
	always_comb begin
		next_sck = clock_polarity_bit;
		if (state == spi_port_pkg::ST_SHIFT)
			next_sck = m_toggle ? !sck_out : sck_out;
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			sck_out  <= 1'b0;
			sck_oe_n <= 1'b1;
			sdo_oe_n <= 1'b1;
		end else begin
			sck_out  <= next_sck;
			sck_oe_n <= !is_master;
			// released when deselected so several slaves can share data out
			sdo_oe_n <= !((is_master || slave_on) && !sdo_dis);
		end
	end

	// shift registers, msb first in both directions
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			tx_sr   <= spi_port_pkg::BYTE_ZERO;
			rx_sr   <= spi_port_pkg::BYTE_ZERO;
			sdo_out <= 1'b0;
			bit_cnt <= 4'h0;
		end else begin
			if (buf_take) begin
				if (cke) begin
					sdo_out <= wdata_bit7(w_byte_h);
					tx_sr   <= {w_byte_h[6:0], 1'b0};
				end else begin
					tx_sr <= w_byte_h;
				end
			end else if (shift_out) begin
				sdo_out <= tx_sr[7];
				tx_sr   <= {tx_sr[6:0], 1'b0};
			end
			if (sample_now)
				rx_sr <= rx_next;
			if (!is_slave || slave_rst || s_done)
				bit_cnt <= 4'h0;
			else if (s_sample)
				bit_cnt <= bit_cnt + 4'h1;
		end
	end

	function automatic logic wdata_bit7(input logic [7:0] b);
		wdata_bit7 = b[7];
	endfunction

	// transfer buffer has no reset so it survives a device reset
	always_ff @(posedge clk) begin
		if (buf_take)
			xfer_buf <= w_byte_h;
		else if (xfer_done && load_ok)
			xfer_buf <= captured;
	end

	// configuration and flags; hardware set wins over software clear
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cfg      <= spi_port_pkg::CFG_RST;
			input_sample_phase_bit      <= 1'b0;
			cke      <= 1'b0;
			sdo_dis  <= 1'b0;
			pie      <= 1'b0;
			write_collision_flag     <= 1'b0;
			rx_ov    <= 1'b0;
			buf_full <= 1'b0;
			pif      <= 1'b0;
		end else begin
			if (wr_ctrl)
				cfg <= w_byte_h[spi_port_pkg::CFG_MSB:0];
			if (wr_stat) begin
				input_sample_phase_bit <= w_byte_h[spi_port_pkg::SMP_BIT];
				cke <= w_byte_h[spi_port_pkg::CKE_BIT];
			end
			if (wr_pinctl)
				sdo_dis <= w_byte_h[spi_port_pkg::SDO_DIS_BIT];
			if (wr_enab)
				pie <= w_byte_h[spi_port_pkg::PIE_BIT];
			write_collision_flag <= collide || (wr_ctrl ?
				w_byte_h[spi_port_pkg::WRITE_COLLISION_FLAG_BIT] : write_collision_flag);
			rx_ov <= ov_set ||
				(wr_ctrl ? w_byte_h[spi_port_pkg::OV_BIT] : rx_ov);
			buf_full <= (xfer_done && load_ok) ||
				(buf_full && !buf_rd);
			pif <= xfer_done || (pif && !(wr_flags &&
				w_byte_h[spi_port_pkg::PIF_BIT]));
		end
	end

	// interrupt and wake
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			irq          <= 1'b0;
			wake_request <= 1'b0;
		end else begin
			irq <= (xfer_done || (pif && !(wr_flags &&
				w_byte_h[spi_port_pkg::PIF_BIT]))) && pie;
			wake_request <= (xfer_done && sleep_mode) ||
				(wake_request && sleep_mode);
		end
	end

	// read word select
	always_comb begin
		rd_word = spi_port_pkg::BYTE_ZERO;
		if (araddr == spi_port_pkg::ADR_FLAGS)
			rd_word[spi_port_pkg::PIF_BIT] = pif;
		if (araddr == spi_port_pkg::ADR_ENAB)
			rd_word[spi_port_pkg::PIE_BIT] = pie;
		if (araddr == spi_port_pkg::ADR_BUF)
			rd_word = xfer_buf;
		if (araddr == spi_port_pkg::ADR_CTRL)
			rd_word = {write_collision_flag, rx_ov, cfg};
		if (araddr == spi_port_pkg::ADR_PINCTL)
			rd_word[spi_port_pkg::SDO_DIS_BIT] = sdo_dis;
		if (araddr == spi_port_pkg::ADR_STAT) begin
			rd_word[spi_port_pkg::SMP_BIT] = input_sample_phase_bit;
			rd_word[spi_port_pkg::CKE_BIT] = cke;
			rd_word[spi_port_pkg::BF_BIT]  = buf_full;
		end
	end

	// axi4-lite handshakes; address and data may come in either order
	assign next_aw_hold = (aw_hold && !wr_go) || (awvalid && awready);
	assign next_w_hold  = (w_hold && !wr_go) || (wvalid && wready);
	assign next_bvalid  = wr_go || (bvalid && !bready);
	assign next_rvalid  = rd_go || (rvalid && !rready);

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			aw_hold   <= 1'b0;
			w_hold    <= 1'b0;
			aw_addr_h <= 12'h000;
			w_byte_h  <= spi_port_pkg::BYTE_ZERO;
			w_strb_h  <= 1'b0;
			awready   <= 1'b0;
			wready    <= 1'b0;
			bvalid    <= 1'b0;
			bresp     <= spi_port_pkg::RESP_OKAY;
		end else begin
			aw_hold <= next_aw_hold;
			w_hold  <= next_w_hold;
			awready <= !next_aw_hold && !next_bvalid;
			wready  <= !next_w_hold && !next_bvalid;
			bvalid  <= next_bvalid;
			if (awvalid && awready)
				aw_addr_h <= awaddr;
			if (wvalid && wready) begin
				w_byte_h <= wdata[7:0];
				w_strb_h <= wstrb[0];
			end
			if (wr_go)
				bresp <= wr_map ? spi_port_pkg::RESP_OKAY :
					spi_port_pkg::RESP_SLVERR;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			arready <= 1'b0;
			rvalid  <= 1'b0;
			rdata   <= 32'h00000000;
			rresp   <= spi_port_pkg::RESP_OKAY;
		end else begin
			arready <= !next_rvalid;
			rvalid  <= next_rvalid;
			if (rd_go) begin
				rdata <= {24'h000000, rd_word};
				rresp <= rd_map ? spi_port_pkg::RESP_OKAY :
					spi_port_pkg::RESP_SLVERR;
			end
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	sequence s_load_ok;
		xfer_done && load_ok;
	endsequence
	sequence s_filled;
		buf_full && xfer_buf == $past(captured);
	endsequence
	property p_rx_load;
		s_load_ok |=> s_filled;
	endproperty
	a_rx_load: assert property (p_rx_load)
		else $error("received byte not loaded into buffer");

	property p_collide;
		collide |=> write_collision_flag && xfer_buf == $past(xfer_buf);
	endproperty
	a_collide: assert property (p_collide)
		else $error("write during transfer not refused");

	property p_start;
		start |=> state == spi_port_pkg::ST_SHIFT;
	endproperty
	a_start: assert property (p_start)
		else $error("master write did not start a transfer");

	property p_flag;
		xfer_done |=> pif;
	endproperty
	a_flag: assert property (p_flag)
		else $error("byte end did not set interrupt flag");

	property p_disabled;
		!en |=> !xfer_busy && sck_oe_n && sdo_oe_n;
	endproperty
	a_disabled: assert property (p_disabled)
		else $error("port active while disabled");

	property p_idle_level;
		!xfer_busy && !$past(xfer_busy) && $stable(clock_polarity_bit) && is_master
			|-> sck_out == clock_polarity_bit;
	endproperty
	a_idle_level: assert property (p_idle_level)
		else $error("serial clock not at idle level");

	property p_ss_reset;
		slave_rst |=> bit_cnt == 4'h0;
	endproperty
	a_ss_reset: assert property (p_ss_reset)
		else $error("select high did not reset slave shifter");

	sequence s_fast_gap;
		!half_tick ##1 half_tick;
	endsequence
	property p_rate4;
		half_tick && !m_done && mode == spi_port_pkg::MODE_DIV4
			&& $stable(cfg) |=> s_fast_gap;
	endproperty
	a_rate4: assert property (p_rate4)
		else $error("fastest rate half period is not two cycles");

	property p_wake;
		xfer_done && sleep_mode |=> wake_request;
	endproperty
	a_wake: assert property (p_wake)
		else $error("received byte did not wake");

	property p_first_bit;
		buf_take && cke |=> sdo_out == $past(w_byte_h[7]);
	endproperty
	a_first_bit: assert property (p_first_bit)
		else $error("first bit not driven before first edge");

	property p_xfer_ends;
		start && mode != spi_port_pkg::MODE_TMR2
			|-> ##[1:600] (xfer_done || !en);
	endproperty
	a_xfer_ends: assert property (p_xfer_ends)
		else $error("master byte did not complete");
endmodule

// *** testbench/spi_far_model.sv ***
// far-side spi device model answering the port in master mode
`timescale 1ns/1ps
module spi_far_model (
	// serial pins
	input  wire logic       sck,
	input  wire logic       mosi,
	input  wire logic       sel,
	output logic            miso,
	// setup and captured data
	input  wire logic       cpol,
	input  wire logic       cke,
	input  wire logic [7:0] tx_byte,
	output logic [7:0]      rx_byte
);
	logic [7:0] sh;
	initial begin
		miso = 1'b0;
		sh = 8'h00;
		rx_byte = 8'h00;
	end
	always @(posedge sel) begin
		sh = tx_byte;
		if (cke) begin
			miso = sh[7];
			sh = {sh[6:0], 1'b0};
		end
	end
	// a released line flips so a stale bit can never pass as data
	always @(negedge sel) miso = ~miso;
	// leading edge is the move away from idle; output edge set by cke
	always @(sck) begin
		if (sel) begin
			if ((sck != cpol) != cke) begin
				miso = sh[7];
				sh = {sh[6:0], 1'b0};
			end else begin
				rx_byte = {rx_byte[6:0], mosi};
			end
		end
	end
endmodule

// *** testbench/tb_top.sv ***
// register-level testbench of the serial peripheral port
`timescale 1ns/1ps
module tb_top;
	logic        clk, rst, awvalid, awready, wvalid, wready, bvalid, bready;
	logic        arvalid, arready, rvalid, rready, sck_in, sck_out, sck_oe_n;
	logic        serial_data_in_pin, sdo_out, sdo_oe_n, ss_n, timer2_tick, sleep_mode, irq;
	logic        wake_request, far_sel, cpol, cke, slave_on, tb_sdi, far_miso;
	logic        sck_prev;
	logic [11:0] awaddr, araddr;
	logic [31:0] wdata, rdata;
	logic [3:0]  wstrb;
	logic [1:0]  bresp, rresp;
	logic [7:0]  far_tx, far_rx, rv, got;
	int          mismatches, total_checks, cyc, last_t, half_seen, ntog, n0;
	int          halves[4] = '{2, 8, 32, 6};

	sync_serial_spi_port sync_serial_spi_port_inst (
		.clk(clk), .rst(rst), .awaddr(awaddr), .awvalid(awvalid),
		.awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
		.wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
		.araddr(araddr), .arvalid(arvalid), .arready(arready),
		.rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
		.sck_in(sck_in), .sck_out(sck_out), .sck_oe_n(sck_oe_n), .serial_data_in_pin(serial_data_in_pin),
		.sdo_out(sdo_out), .sdo_oe_n(sdo_oe_n), .ss_n(ss_n),
		.timer2_tick(timer2_tick), .sleep_mode(sleep_mode),
		.wake_request(wake_request), .irq(irq)
	);
	spi_far_model spi_far_model_inst (
		.sck(sck_out), .mosi(sdo_out), .sel(far_sel), .miso(far_miso),
		.cpol(cpol), .cke(cke), .tx_byte(far_tx), .rx_byte(far_rx)
	);
	assign serial_data_in_pin = slave_on ? tb_sdi : far_miso;

	always #5 clk = ~clk;
	// timer pulse every six cycles; serial clock half periods are logged
	always @(posedge clk) begin
		cyc++;
		timer2_tick <= (cyc % 6 == 0);
		if (sck_out !== sck_prev) begin
			half_seen = cyc - last_t;
			last_t = cyc;
			ntog++;
		end
		sck_prev = sck_out;
	end

	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e,
			input logic [31:0] g);
		total_checks++;
		if (g !== e) begin
			mismatches++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic give_up(input string nm);
		mismatches++;
		$display("[FAIL] %s expected answer seen timeout", nm);
		tally_and_finish();
	endtask
	task automatic wr(input logic [11:0] a, input logic [7:0] d,
			input logic [1:0] er = 2'h0);
		int n;
		@(posedge clk);
		awaddr <= a;
		wdata <= {24'h0, d};
		wstrb <= 4'h1;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (n = 0; n < 200; n++) begin
			@(posedge clk);
			if (awready)
				awvalid <= 1'b0;
			if (wready)
				wvalid <= 1'b0;
			if (bvalid)
				break;
		end
		if (n == 200)
			give_up("write");
		bready <= 1'b0;
		chk("bresp", er, bresp);
	endtask
	// an empty name reads without comparing, for polling
	task automatic rd(input logic [11:0] a, input logic [7:0] e,
			input string nm, input logic [1:0] er = 2'h0);
		int n;
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (n = 0; n < 200; n++) begin
			@(posedge clk);
			if (arready)
				arvalid <= 1'b0;
			if (rvalid)
				break;
		end
		if (n == 200)
			give_up("read");
		rready <= 1'b0;
		rv = rdata[7:0];
		if (nm != "") begin
			chk(nm, e, rdata);
			chk("rresp", er, rresp);
		end
	endtask
	// reconfigure with the port disabled first
	task automatic cfg(input logic [7:0] ct, input logic [7:0] st);
		wr(spi_port_pkg::ADR_CTRL, 8'h00);
		wr(spi_port_pkg::ADR_STAT, st);
		wr(spi_port_pkg::ADR_CTRL, ct);
		cpol = ct[4];
		cke = st[6];
		// let the registered pin outputs follow the new setup
		@(posedge clk);
	endtask
	task automatic start(input logic [7:0] m);
		@(posedge clk);
		far_tx <= ~m;
		far_sel <= 1'b1;
		wr(spi_port_pkg::ADR_BUF, m);
	endtask
	task automatic finish(input logic [7:0] m, input bit rx_on);
		int n;
		for (n = 0; n < 2000; n++) begin
			@(posedge clk);
			if (irq === 1'b1)
				break;
		end
		if (n == 2000)
			give_up("irq");
		far_sel <= 1'b0;
		rd(spi_port_pkg::ADR_BUF, ~m, "rx byte");
		if (rx_on)
			chk("tx byte", m, far_rx);
		wr(spi_port_pkg::ADR_FLAGS, 8'h08);
		rd(spi_port_pkg::ADR_FLAGS, 8'h00, "flag clear");
		chk("irq low", 0, irq);
	endtask
	// bench acts as external master in slave mode, cpol 0 and cke 1
	task automatic slave_byte(input logic [7:0] tx, input int nb);
		@(posedge clk);
		ss_n <= 1'b0;
		repeat (10) @(posedge clk);
		for (int b = 7; b > 7 - nb; b--) begin
			tb_sdi <= tx[b];
			repeat (10) @(posedge clk);
			sck_in <= 1'b1;
			got[b] = sdo_out;
			repeat (10) @(posedge clk);
			sck_in <= 1'b0;
		end
		repeat (10) @(posedge clk);
		ss_n <= 1'b1;
		tb_sdi <= ~tb_sdi;
		repeat (10) @(posedge clk);
	endtask

	initial begin
		clk = 0;
		rst = 1;
		{awvalid, wvalid, bready, arvalid, rready, sck_in, sleep_mode} = 0;
		{far_sel, cpol, cke, slave_on, tb_sdi, timer2_tick} = 0;
		ss_n = 1;
		awaddr = 0;
		araddr = 0;
		wdata = 0;
		wstrb = 0;
		far_tx = 0;
		got = 0;
		repeat (5) @(posedge clk);
		rst <= 0;
		rd(spi_port_pkg::ADR_CTRL, 8'h00, "ctrl reset");
		rd(spi_port_pkg::ADR_STAT, 8'h00, "stat reset");
		rd(spi_port_pkg::ADR_FLAGS, 8'h00, "flags reset");
		rd(spi_port_pkg::ADR_ENAB, 8'h00, "enab reset");
		rd(12'h400, 8'h00, "unmapped", 2'h2);
		wr(12'h400, 8'hFF, 2'h2);
		chk("sck oe reset", 1, sck_oe_n);
		wr(spi_port_pkg::ADR_ENAB, 8'h08);
		for (int i = 0; i < 4; i++) begin
			cfg(8'h20 | i[7:0], 8'h40);
			chk("sck drive", 0, sck_oe_n);
			start(8'h96 + i[7:0]);
			finish(8'h96 + i[7:0], 1);
			chk("half period", halves[i], half_seen);
		end
		for (int c = 0; c < 8; c++) begin
			cfg({3'h1, c[0], 4'h1}, {c[1], c[2], 6'h0});
			chk("sck idle", c[0], sck_out);
			start(8'hA0 | c[7:0]);
			finish(8'hA0 | c[7:0], 1);
		end
		cfg(8'h22, 8'h40);
		start(8'hC3);
		wr(spi_port_pkg::ADR_BUF, 8'h11);
		rd(spi_port_pkg::ADR_CTRL, 8'hA2, "collision");
		finish(8'hC3, 1);
		wr(spi_port_pkg::ADR_PINCTL, 8'h01);
		wr(spi_port_pkg::ADR_ENAB, 8'h00);
		start(8'h5A);
		chk("sdo released", 1, sdo_oe_n);
		for (int n = 0; n < 1000 && !rv[3]; n++)
			rd(spi_port_pkg::ADR_FLAGS, 8'h00, "");
		chk("masked irq", 0, irq);
		wr(spi_port_pkg::ADR_ENAB, 8'h08);
		repeat (2) @(posedge clk);
		chk("unmasked irq", 1, irq);
		finish(8'h5A, 0);
		wr(spi_port_pkg::ADR_PINCTL, 8'h00);
		cfg(8'h00, 8'h40);
		chk("sck released", 1, sck_oe_n);
		n0 = ntog;
		wr(spi_port_pkg::ADR_BUF, 8'h77);
		repeat (40) @(posedge clk);
		chk("no clock", n0, ntog);
		cfg(8'h24, 8'h40);
		slave_on <= 1'b1;
		sleep_mode <= 1'b1;
		wr(spi_port_pkg::ADR_BUF, 8'hA5);
		slave_byte(8'h5A, 8);
		chk("slave tx", 8'hA5, got);
		chk("wake", 1, wake_request);
		rd(spi_port_pkg::ADR_STAT, 8'h41, "full set");
		rd(spi_port_pkg::ADR_BUF, 8'h5A, "slave rx");
		rd(spi_port_pkg::ADR_STAT, 8'h40, "full clear");
		rd(spi_port_pkg::ADR_FLAGS, 8'h08, "slave flag");
		sleep_mode <= 1'b0;
		wr(spi_port_pkg::ADR_FLAGS, 8'h08);
		slave_byte(8'hFF, 3);
		slave_byte(8'h3C, 8);
		rd(spi_port_pkg::ADR_BUF, 8'h3C, "after abort");
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		rd(spi_port_pkg::ADR_BUF, 8'h3C, "kept buffer");
		rd(spi_port_pkg::ADR_CTRL, 8'h00, "ctrl after reset");
		tally_and_finish();
	end
endmodule
